// ===== src/cfg_header_regs.v
// Configuration header register bank with EEPROM-driven board identity load.
// Assumes single-cycle config strobes and EEPROM words delivered on this clock.
`timescale 1ns/1ns
`default_nettype none
`include "cfg_header_defs.vh"

module cfg_header_regs #(
  parameter [7:0] REV_DEFAULT = 8'h01, // Arbitrary value
  parameter [15:0] BOARD_ID_DEFAULT = 16'h0000
) (
  input wire CLK_SYS,
  input wire RST_B,
  input wire CE,
  input wire CFG_REQ,
  input wire CFG_WR,
  input wire [5:0] CFG_IDX,
  input wire [3:0] CFG_BE,
  input wire [31:0] CFG_WDATA,
  output reg CFG_ACK,
  output reg CFG_RETRY,
  output reg [31:0] CFG_RDATA,
  output wire EE_REQ,
  output wire [7:0] EE_ADDR,
  input wire EE_VALID,
  input wire [15:0] EE_DATA,
  output wire LOAD_DONE,
  output wire MWI_ENABLE,
  output wire [7:0] MASTER_HOLD_CYCLES,
  output wire [7:0] LINE_SIZE_DWORDS
);

  localparam [1:0] ST_FETCH_CTRL = 2'h0;
  localparam [1:0] ST_FETCH_PRODUCT = 2'h1;
  localparam [1:0] ST_FETCH_MAKER = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [15:0] ctrl_word_reg;
  reg [15:0] board_product_id_reg;
  reg [15:0] board_maker_id_reg;
  reg [7:0] rev_reg;
  reg [7:0] line_size_reg;
  reg [7:0] master_hold_timer_reg;
  reg [31:`MEM_WIN_LSB] mem_base_reg;
  reg [31:`IO_WIN_LSB] io_base_reg;
  reg [31:`FLASH_WIN_LSB] flash_base_reg;
  reg [31:`ROM_WIN_LSB] rom_base_reg;
  reg [31:0] rd_value;
  reg [31:0] mem_merged;
  reg [31:0] io_merged;
  reg [31:0] flash_merged;
  reg [31:0] rom_merged;
  reg [7:0] ee_addr_reg;
  reg mwi_reg;

  wire ee_present;
  wire rom_disabled;
  wire cfg_wr_go;

  // Merge written bytes into an old value
  function [31:0] merge_bytes;
    input [31:0] old_value;
    input [31:0] new_value;
    input [3:0] be;
    integer i;
    begin
      merge_bytes = old_value;
      for (i = 0; i < 4; i = i + 1)
      begin
        if (be[i])
        begin
          merge_bytes[i*8 +: 8] = new_value[i*8 +: 8];
        end
      end
    end
  endfunction

  // Control word marks an attached EEPROM
  function ee_pattern_ok;
    input [15:0] word;
    begin
      ee_pattern_ok = (word[`EE_PRESENT_HI:`EE_PRESENT_LO] == `EE_PRESENT_PAT);
    end
  endfunction

  // Only the two supported line sizes are kept
  function line_size_ok;
    input [7:0] value;
    begin
      line_size_ok = (value == `LINE_SIZE_8) || (value == `LINE_SIZE_16);
    end
  endfunction

  // Word address fetched in a given load state
  function [7:0] word_for_state;
    input [1:0] st;
    begin
      case (st)
        ST_FETCH_CTRL:
        begin
          word_for_state = `EE_WORD_CTRL;
        end
        ST_FETCH_PRODUCT:
        begin
          word_for_state = `EE_WORD_PRODUCT;
        end
        default:
        begin
          word_for_state = `EE_WORD_MAKER;
        end
      endcase
    end
  endfunction

  assign ee_present = ee_pattern_ok(ctrl_word_reg);
  assign rom_disabled = ctrl_word_reg[`EE_ROM_DIS_BIT];
  assign LOAD_DONE = (state_reg == ST_DONE);
  assign EE_REQ = !LOAD_DONE;
  assign EE_ADDR = ee_addr_reg;
  assign MWI_ENABLE = mwi_reg;
  assign MASTER_HOLD_CYCLES = master_hold_timer_reg;
  assign LINE_SIZE_DWORDS = line_size_reg;
  assign cfg_wr_go = CFG_REQ && CFG_WR && LOAD_DONE;

  // EEPROM load sequencer: control word, then product, then maker
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_FETCH_CTRL:
      begin
        if (EE_VALID)
        begin
          state_next = ST_FETCH_PRODUCT;
        end
      end
      ST_FETCH_PRODUCT:
      begin
        if (EE_VALID)
        begin
          state_next = ST_FETCH_MAKER;
        end
      end
      ST_FETCH_MAKER:
      begin
        if (EE_VALID)
        begin
          state_next = ST_DONE;
        end
      end
      default:
      begin
        state_next = ST_DONE;
      end
    endcase
  end

  // Read mux
  always @*
  begin
    rd_value = 32'h0000_0000;
    case (CFG_IDX)
      `IDX_CLASS_REV:
      begin
        rd_value = {`CLASS_BASE, `CLASS_SUB, `CLASS_PROG, rev_reg};
      end
      `IDX_MISC:
      begin
        rd_value = {8'h00, `HEADER_LAYOUT_VAL, master_hold_timer_reg, line_size_reg};
      end
      `IDX_MEM_WIN:
      begin
        rd_value = {mem_base_reg, {`MEM_WIN_LSB{1'b0}}};
        rd_value[`MEM_PREFETCH_BIT] = 1'b1;
      end
      `IDX_IO_WIN:
      begin
        rd_value = {io_base_reg, {(`IO_WIN_LSB-1){1'b0}}, 1'b1};
      end
      `IDX_FLASH_WIN:
      begin
        rd_value = {flash_base_reg, {`FLASH_WIN_LSB{1'b0}}};
      end
      `IDX_BOARD_ID:
      begin
        rd_value = {board_product_id_reg, board_maker_id_reg};
      end
      `IDX_ROM_WIN:
      begin
        if (!rom_disabled)
        begin
          rd_value = {rom_base_reg, {`ROM_WIN_LSB{1'b0}}};
        end
      end
      default:
      begin
        rd_value = 32'h0000_0000;
      end
    endcase
  end

  // Byte-merged write images of the windows
  always @*
  begin
    mem_merged = merge_bytes({mem_base_reg, {`MEM_WIN_LSB{1'b0}}}, CFG_WDATA, CFG_BE);
    io_merged = merge_bytes({io_base_reg, {`IO_WIN_LSB{1'b0}}}, CFG_WDATA, CFG_BE);
    flash_merged = merge_bytes({flash_base_reg, {`FLASH_WIN_LSB{1'b0}}}, CFG_WDATA, CFG_BE);
    rom_merged = merge_bytes({rom_base_reg, {`ROM_WIN_LSB{1'b0}}}, CFG_WDATA, CFG_BE);
  end

  // EEPROM load registers
  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      state_reg <= ST_FETCH_CTRL;
      ee_addr_reg <= `EE_WORD_CTRL;
      ctrl_word_reg <= 16'h0000;
      board_product_id_reg <= 16'h0000;
      board_maker_id_reg <= 16'h0000;
      rev_reg <= 8'h00;
    end
    else if (CE)
    begin
      state_reg <= state_next;
      ee_addr_reg <= word_for_state(state_next);
      if (state_reg == ST_FETCH_CTRL)
      begin
        // Defaults apply until the control word says otherwise
        rev_reg <= REV_DEFAULT;
        board_product_id_reg <= BOARD_ID_DEFAULT;
        board_maker_id_reg <= BOARD_ID_DEFAULT;
      end
      if (EE_VALID && (state_reg == ST_FETCH_CTRL))
      begin
        ctrl_word_reg <= EE_DATA;
        if (ee_pattern_ok(EE_DATA) && EE_DATA[`EE_REV_EN_BIT])
        begin
          rev_reg <= {REV_DEFAULT[7:3], EE_DATA[`EE_REV_HI:`EE_REV_LO]};
        end
      end
      if (EE_VALID && (state_reg == ST_FETCH_PRODUCT) && ee_present)
      begin
        board_product_id_reg <= EE_DATA;
      end
      if (EE_VALID && (state_reg == ST_FETCH_MAKER) && ee_present)
      begin
        board_maker_id_reg <= EE_DATA;
      end
    end
  end

  // Config access answer: complete, or Retry while loading
  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      CFG_ACK <= 1'b0;
      CFG_RETRY <= 1'b0;
      CFG_RDATA <= 32'h0000_0000;
    end
    else if (CE)
    begin
      CFG_ACK <= CFG_REQ && LOAD_DONE;
      CFG_RETRY <= CFG_REQ && !LOAD_DONE;
      // Read data holds until the next completed read
      if (CFG_REQ && !CFG_WR && LOAD_DONE)
      begin
        CFG_RDATA <= rd_value;
      end
    end
  end

  // Writable header fields
  always @(posedge CLK_SYS)
  begin
    if (!RST_B)
    begin
      line_size_reg <= 8'h00;
      mwi_reg <= 1'b0;
      master_hold_timer_reg <= 8'h00;
      mem_base_reg <= {(32-`MEM_WIN_LSB){1'b0}};
      io_base_reg <= {(32-`IO_WIN_LSB){1'b0}};
      flash_base_reg <= {(32-`FLASH_WIN_LSB){1'b0}};
      rom_base_reg <= {(32-`ROM_WIN_LSB){1'b0}};
    end
    else if (CE && cfg_wr_go)
    begin
      case (CFG_IDX)
        `IDX_MISC:
        begin
          if (CFG_BE[0])
          begin
            if (line_size_ok(CFG_WDATA[7:0]))
            begin
              line_size_reg <= CFG_WDATA[7:0];
              mwi_reg <= 1'b1;
            end
            else
            begin
              line_size_reg <= 8'h00;
              mwi_reg <= 1'b0;
            end
          end
          if (CFG_BE[1])
          begin
            master_hold_timer_reg <= CFG_WDATA[15:8];
          end
        end
        // Windows keep only their size-matching upper bits
        `IDX_MEM_WIN:
        begin
          mem_base_reg <= mem_merged[31:`MEM_WIN_LSB];
        end
        `IDX_IO_WIN:
        begin
          io_base_reg <= io_merged[31:`IO_WIN_LSB];
        end
        `IDX_FLASH_WIN:
        begin
          flash_base_reg <= flash_merged[31:`FLASH_WIN_LSB];
        end
        `IDX_ROM_WIN:
        begin
          // Disabled window ignores writes
          if (!rom_disabled)
          begin
            rom_base_reg <= rom_merged[31:`ROM_WIN_LSB];
          end
        end
        default:
        begin
          line_size_reg <= line_size_reg;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ===== pkg/cfg_header_defs.vh
// Constants for the configuration header register bank.
// Assumes dword-indexed configuration accesses and a word-wide EEPROM fetch port.
// Summary of operation
// - Class code reads network, Ethernet, zero interface
// - Line size keeps only 8 or 16
// - Other line size writes read back zero
// - Bit 3 or 4 set only by exact value
// - Master hold timer bounds bus ownership cycles
// - Header layout reads zero, single function
// - Window bit 0: memory zero, I/O one
// - I/O window bit 1 reads zero
// - Only size-matching upper window bits writable
// - Control block memory window 4 Kbyte prefetchable
// - Control block I/O window 64 bytes
// - Flash window always requests 128 Kbyte
// - ROM window requests 1 MB when enabled
// - ROM disable flag makes ROM window zero
// - After reset fetch EEPROM words A, B, C
// - Present pattern 01b loads board IDs
// - Present with bit 13 overrides revision low bits
// - Retry all configuration accesses until load done
`ifndef CFG_HEADER_DEFS_VH
`define CFG_HEADER_DEFS_VH

// Dword indices of the configuration header
`define IDX_CLASS_REV 6'h02
`define IDX_MISC 6'h03
`define IDX_MEM_WIN 6'h04
`define IDX_IO_WIN 6'h05
`define IDX_FLASH_WIN 6'h06
`define IDX_BOARD_ID 6'h0B
`define IDX_ROM_WIN 6'h0C

// Class code fields
`define CLASS_BASE 8'h02
`define CLASS_SUB 8'h00
`define CLASS_PROG 8'h00
`define HEADER_LAYOUT_VAL 8'h00

// Accepted line sizes
`define LINE_SIZE_8 8'h08
`define LINE_SIZE_16 8'h10

// Lowest writable bit of each window
`define MEM_WIN_LSB 12
`define IO_WIN_LSB 6
`define FLASH_WIN_LSB 17
`define ROM_WIN_LSB 20
`define MEM_PREFETCH_BIT 3

// EEPROM words and control word fields
`define EE_WORD_CTRL 8'h0A
`define EE_WORD_PRODUCT 8'h0B
`define EE_WORD_MAKER 8'h0C
`define EE_PRESENT_PAT 2'h1
`define EE_PRESENT_HI 15
`define EE_PRESENT_LO 14
`define EE_REV_EN_BIT 13
`define EE_ROM_DIS_BIT 11
`define EE_REV_HI 10
`define EE_REV_LO 8

`endif

// ===== sim/ee_model.sv
// EEPROM stand-in that hands out the three load words.
// Assumes the fetch port runs on the bench clock.
`timescale 1ns/1ns
`default_nettype none
module ee_model (
  input wire logic clk,
  input wire logic req,
  input wire logic [7:0] addr,
  input wire logic [2:0] lag,
  input wire logic [47:0] words,
  output var logic valid,
  output var logic [15:0] data
);
  logic [2:0] cnt = 3'h0;
  initial valid = 1'b0;
  initial data = 16'h0000;
  always @(posedge clk)
  begin
    valid <= 1'b0;
    data <= ~data; // No stale word between deliveries
    cnt <= cnt + 3'h1;
    if (req && !valid && cnt >= lag)
    begin
      valid <= 1'b1;
      data <= words[(addr - 8'h0A) * 16 +: 16];
      cnt <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/cfg_hdr_checker.sv
// Concurrent checks on the config header bank.
// Sees only the bank's ports; bound below.
`timescale 1ns/1ns
`default_nettype none
module cfg_hdr_checker (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic CE,
  input wire logic CFG_REQ,
  input wire logic CFG_WR,
  input wire logic [5:0] CFG_IDX,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic CFG_ACK,
  input wire logic CFG_RETRY,
  input wire logic [31:0] CFG_RDATA,
  input wire logic EE_REQ,
  input wire logic [7:0] EE_ADDR,
  input wire logic EE_VALID,
  input wire logic LOAD_DONE,
  input wire logic MWI_ENABLE,
  input wire logic [7:0] LINE_SIZE_DWORDS
);
  logic [7:0] w8;
  logic [7:0] ls_want;
  assign w8 = CFG_WDATA[7:0];
  always @(posedge CLK_SYS)
    ls_want <= (w8 == 8'h08 || w8 == 8'h10) ? w8 : 8'h00;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  sequence s_acc(w, i);
    CE && CFG_REQ && LOAD_DONE && CFG_WR == w && CFG_IDX == i;
  endsequence
  sequence s_ee(a);
    CE && EE_REQ && EE_VALID && EE_ADDR == a;
  endsequence
  property p_ans;
    CE && CFG_REQ |=> CFG_ACK != CFG_RETRY && CFG_RETRY == !$past(LOAD_DONE);
  endproperty
  property p_ls;
    s_acc(1'b1, 6'h03) ##0 CFG_BE[0] |=>
      LINE_SIZE_DWORDS == ls_want && MWI_ENABLE == (ls_want != 8'h00);
  endproperty
  property p_ee;
    CE && EE_REQ && EE_VALID && EE_ADDR != 8'h0C |=> EE_REQ && EE_ADDR == $past(EE_ADDR) + 8'h01;
  endproperty
  property p_lsrd; s_acc(1'b0, 6'h03) |=> CFG_RDATA[7:0] == $past(LINE_SIZE_DWORDS); endproperty
  property p_cls; s_acc(1'b0, 6'h02) |=> CFG_RDATA[31:8] == 24'h020000; endproperty
  property p_mem; s_acc(1'b0, 6'h04) |=> CFG_RDATA[11:0] == 12'h008; endproperty
  property p_io; s_acc(1'b0, 6'h05) |=> CFG_RDATA[5:0] == 6'h01; endproperty
  property p_done; s_ee(8'h0C) |=> LOAD_DONE && !EE_REQ; endproperty
  a_ans: assert property (p_ans) else $error("bad answer");
  a_ls: assert property (p_ls) else $error("bad line size");
  a_ee: assert property (p_ee) else $error("bad word order");
  a_lsrd: assert property (p_lsrd) else $error("bad size read");
  a_cls: assert property (p_cls) else $error("bad class");
  a_mem: assert property (p_mem) else $error("bad mem window");
  a_io: assert property (p_io) else $error("bad io window");
  a_done: assert property (p_done) else $error("bad load end");
endmodule
bind cfg_header_regs cfg_hdr_checker chk (.CLK_SYS, .RST_B, .CE, .CFG_REQ, .CFG_WR,
  .CFG_IDX, .CFG_BE, .CFG_WDATA, .CFG_ACK, .CFG_RETRY, .CFG_RDATA, .EE_REQ, .EE_ADDR,
  .EE_VALID, .LOAD_DONE, .MWI_ENABLE, .LINE_SIZE_DWORDS);
`default_nettype wire

// ===== sim/tb.sv
// Bench for the config header bank with an EEPROM model.
// Inputs change on falling edges; three reset runs with varied control words.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk_sys, rst_b, ce, cfg_req, cfg_wr, cfg_ack, cfg_retry, ee_req, ee_valid, done, mwi;
  logic rt0;
  logic [5:0] cfg_idx, j;
  logic [3:0] cfg_be;
  logic [31:0] cfg_wdata, cfg_rdata, v, r;
  logic [7:0] ee_addr, hold, ls;
  logic [15:0] ee_data, wa;
  logic [47:0] words;
  logic [2:0] lag;
  integer fails, tests_run, seed, run, k, n;
  cfg_header_regs #(.REV_DEFAULT(8'h02)) uut (.CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce),
    .CFG_REQ(cfg_req), .CFG_WR(cfg_wr), .CFG_IDX(cfg_idx), .CFG_BE(cfg_be),
    .CFG_WDATA(cfg_wdata), .CFG_ACK(cfg_ack), .CFG_RETRY(cfg_retry), .CFG_RDATA(cfg_rdata),
    .EE_REQ(ee_req), .EE_ADDR(ee_addr), .EE_VALID(ee_valid), .EE_DATA(ee_data),
    .LOAD_DONE(done), .MWI_ENABLE(mwi), .MASTER_HOLD_CYCLES(hold), .LINE_SIZE_DWORDS(ls));
  ee_model eep (.clk(clk_sys), .req(ee_req), .addr(ee_addr), .lag(lag), .words(words),
    .valid(ee_valid), .data(ee_data));
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task check(input [31:0] got, input [31:0] exp);
  begin
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("BAD t=%0t seen=%h want=%h", $time, got, exp);
    end
  end
  endtask
  task wrap_up;
  begin
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task acc(input w, input [5:0] i, input [31:0] d, input [3:0] be);
  begin
    for (n = 0; n < 40; n = n + 1)
    begin
      @(negedge clk_sys);
      {cfg_req, cfg_wr, cfg_idx, cfg_wdata, cfg_be} = {1'b1, w, i, d, be};
      @(negedge clk_sys);
      cfg_req = 1'b0;
      if (n == 0)
        rt0 = cfg_retry;
      if (cfg_ack === 1'b1)
        n = 99;
    end
    if (n == 40)
    begin
      fails = fails + 1;
      wrap_up;
    end
  end
  endtask
  task rd(input [5:0] i, input [31:0] e);
  begin
    acc(1'b0, i, 32'h0, 4'h0);
    check(cfg_rdata, e);
  end
  endtask
  function [31:0] bar(input [5:0] i, input [31:0] d);
    case (i)
      6'h04: bar = {d[31:12], 12'h008};
      6'h05: bar = {d[31:6], 6'h01};
      6'h06: bar = {d[31:17], 17'h0};
      default: bar = wa[11] ? 32'h0 : {d[31:20], 20'h0};
    endcase
  endfunction
  function [7:0] lsx(input [7:0] d);
    lsx = (d == 8'h08 || d == 8'h10) ? d : 8'h00;
  endfunction
  initial
  begin
    {rst_b, ce, cfg_req, cfg_wr, cfg_idx, cfg_be, cfg_wdata} = {2'b01, 44'h0};
    {fails, tests_run, seed, lag, words} = {32'h0, 32'h0, 32'hDB39, 51'h0};
    for (run = 0; run < 3; run = run + 1)
    begin
      wa = run == 0 ? 16'h6D00 : run == 1 ? 16'h4300 : 16'hE700;
      r = $random(seed);
      words = {r, wa};
      lag = r[2:0];
      rst_b = 1'b0;
      repeat (10) @(negedge clk_sys);
      rst_b = 1'b1;
      acc(1'b1, 6'h02, 32'hFFFFFFFF, 4'hF);
      check(rt0, 1'b1);
      check({done, ee_req}, 2'b10);
      rd(6'h02, {24'h020000, 5'h0, wa[15:13] == 3'b011 ? wa[10:8] : 3'h2});
      rd(6'h0B, wa[15:14] == 2'b01 ? {words[31:16], words[47:32]} : 32'h0);
      rd(6'h3F, 32'h0);
      for (k = 0; k < 7; k = k + 1)
      begin
        r = $random(seed);
        v = {r[31:8], k == 0 ? 8'h08 : k == 1 ? 8'h10 : k == 2 ? 8'h09 : k == 3 ? 8'h18 : r[7:0]};
        acc(1'b1, 6'h03, v, 4'h3);
        check(ls, lsx(v[7:0]));
        check(mwi, lsx(v[7:0]) != 8'h00);
        check(hold, v[15:8]);
        rd(6'h03, {16'h0000, v[15:8], lsx(v[7:0])});
      end
      // Write with the clock enable low must change nothing
      @(negedge clk_sys);
      {ce, cfg_req, cfg_wr, cfg_idx, cfg_be} = {3'b011, 6'h03, 4'h1};
      cfg_wdata = {24'h0, lsx(v[7:0]) == 8'h10 ? 8'h08 : 8'h10};
      @(negedge clk_sys);
      {ce, cfg_req} = 2'b10;
      check(cfg_ack, 1'b0);
      check(ls, lsx(v[7:0]));
      for (k = 0; k < 8; k = k + 1)
      begin
        r = $random(seed);
        v = k < 4 ? 32'hFFFFFFFF : r;
        j = k % 4 == 3 ? 6'h0C : 6'h04 + k % 4;
        acc(1'b1, j, v, 4'hF);
        rd(j, bar(j, v));
      end
    end
    wrap_up;
  end
endmodule
`default_nettype wire
